// *** design/gt_pkg.sv ***
// Package for the three-channel timer block: register map, field layout, carriers
// Operation
// - Compare B match sets its flag and interrupt
// - Compare B match drives pin B action
// - Pin B actions only when pin B output
// - Compare C match sets its flag and interrupt
// - Compare C restart bit resets counter next tick
// - Compare C clock-off bit disables counter clock
// - Compare C halt bit stops the counter
// - Compare C match drives pin A action
// - Compare C match drives pin B action
// - Channel 0 pin A clocks channel 1
// - Soft reset bit resets all three channels
// - Sync bit triggers all three channels together
// - Channel 0 clock select: input, none, A1, A2
// - Channel 1 clock select: input, none, A0, A2
// - Channel 2 clock select: input, none, A0, A1
// - Pin actions: none, set, clear, toggle
// - Pin B priority: soft, event, C, B
package gt_pkg;
    // Byte offsets; channel n page is address[9:8] == n
    localparam logic [11:0] BLK_CTRL   = 12'h000;
    localparam logic [11:0] BLK_CLKSEL = 12'h004;
    localparam logic [7:0]  CH_MODE    = 8'h60;
    localparam logic [7:0]  CH_STATUS  = 8'h70;
    localparam logic [7:0]  CH_IEN     = 8'h74;
    localparam logic [7:0]  CH_IDIS    = 8'h78;
    localparam logic [7:0]  CH_IMASK   = 8'h7C;
    localparam logic [7:0]  CH_CNT     = 8'h80;
    localparam logic [7:0]  CH_CMPA    = 8'h84;
    localparam logic [7:0]  CH_CMPB    = 8'h88;
    localparam logic [7:0]  CH_CMPC    = 8'h8C;
    localparam int          NUM_CH     = 3;
    // Block control bits
    localparam int BC_BLOCK_SOFT_RESET = 0;
    localparam int BC_SYNC  = 1;
    localparam int SEL_W    = 2;
    localparam logic [5:0] CLKSEL_MASK = 6'h3F;
    // Mode register fields
    localparam int MD_EXTCLK  = 0;
    localparam int MD_HALT    = 6;
    localparam int MD_CLKOFF  = 7;
    localparam int MD_EVSEL   = 10;
    localparam int MD_RESTART = 14;
    localparam int MD_ACPA    = 16;
    localparam int MD_PIN_A_ON_COMPARE_C    = 18;
    localparam int MD_PIN_B_ON_COMPARE_B    = 24;
    localparam int MD_PIN_B_ON_COMPARE_C    = 26;
    localparam int MD_PIN_B_ON_EXTERNAL_EVENT   = 28;
    localparam int MD_PIN_B_ON_SOFT_TRIGGER  = 30;
    localparam logic [31:0] MODE_MASK = 32'hFF0F_4CC1;
    // Status fields
    localparam int ST_COV    = 0;
    localparam int ST_CPA    = 2;
    localparam int ST_CPB    = 3;
    localparam int ST_CPC    = 4;
    localparam int ST_ETRG   = 7;
    localparam int ST_CLKSTA = 8;
    localparam int ST_MPA    = 9;
    localparam int ST_MPB    = 10;
    localparam logic [7:0] FLAG_MASK = 8'h9D;
    // Pin action codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_SET  = 2'h1;
    localparam logic [1:0] ACT_CLR  = 2'h2;
    localparam logic [1:0] ACT_TOG  = 2'h3;
    // Clock source codes
    localparam logic [1:0] SRC_PIN  = 2'h0;
    localparam logic [1:0] SRC_NONE = 2'h1;
    localparam logic [1:0] SRC_LO   = 2'h2;
    localparam logic [1:0] SRC_HI   = 2'h3;
    localparam logic [1:0] EV_PIN_IN = 2'h0;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [11:0] address;
        logic [31:0] writedata;
    } gt_avl_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } gt_avl_rsp_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] ra;
        logic [15:0] rb;
        logic [15:0] rc;
        logic [31:0] mode;
        logic [7:0]  flags;
        logic [7:0]  imask;
        logic        clken;
        logic        pend;
        logic        pa;
        logic        pb;
        logic        pboe;
        logic        clk_prev;
        logic        evt_prev;
        logic        irq;
    } gt_chan_t;

    typedef struct packed {
        gt_chan_t [NUM_CH-1:0] ch;
        logic [5:0]            clksel;
        logic                  ack;
        gt_avl_rsp_t           rsp;
    } gt_state_t;
endpackage

// *** design/gt_timer_block.sv ***
// Three-channel 16-bit timer block with compare chain and Avalon-MM register slave
`timescale 1ns/1ps
module gt_timer_block (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire gt_pkg::gt_avl_req_t bus_req,
    output gt_pkg::gt_avl_rsp_t      bus_rsp,
    input  wire logic                clock_input_0,
    input  wire logic                clock_input_1,
    input  wire logic                clock_input_2,
    input  wire logic [2:0]          event_in,
    output logic [2:0]               waveform_pin_a,
    output logic [2:0]               waveform_pin_b,
    output logic [2:0]               waveform_pin_b_oe,
    output logic [2:0]               chan_irq
);
    gt_pkg::gt_state_t r;
    gt_pkg::gt_state_t next_r;
    logic [2:0]        ext_v;
    logic [2:0]        tick_v;
    logic [2:0]        hit_b;
    logic [2:0]        hit_c;
    logic              sw_rst_now;
    logic              sync_now;

    function automatic logic pin_act(input logic cur, input logic [1:0] code);
        unique case (code)
            gt_pkg::ACT_NONE: pin_act = cur;
            gt_pkg::ACT_SET:  pin_act = 1'b1;
            gt_pkg::ACT_CLR:  pin_act = 1'b0;
            gt_pkg::ACT_TOG:  pin_act = ~cur;
        endcase
    endfunction

    always_comb begin
        logic [2:0]  clk_in;
        logic [1:0]  sel;
        logic [15:0] nc;
        logic        evt;
        logic        hit_a;
        logic        wr_ch;
        logic        rd_now;
        logic        wr_now;
        logic [7:0]  off;
        logic [1:0]  cix;
        logic [31:0] rd;
        clk_in = {clock_input_2, clock_input_1, clock_input_0};
        sel    = '0;
        nc     = '0;
        evt    = 1'b0;
        hit_a  = 1'b0;
        wr_ch  = 1'b0;
        rd     = '0;
        ext_v  = '0;
        tick_v = '0;
        hit_b  = '0;
        hit_c  = '0;
        next_r = r;
        off    = bus_req.address[7:0];
        cix    = bus_req.address[9:8];
        // One wait state: prepare in the first cycle, complete in the second
        rd_now = bus_req.read && !r.ack;
        wr_now = bus_req.write && r.ack;
        next_r.ack = (bus_req.read || bus_req.write) && !r.ack;
        next_r.rsp.waitrequest = !next_r.ack;
        sw_rst_now = wr_now && bus_req.address == gt_pkg::BLK_CTRL
                     && bus_req.writedata[gt_pkg::BC_BLOCK_SOFT_RESET];
        sync_now = wr_now && bus_req.address == gt_pkg::BLK_CTRL
                   && bus_req.writedata[gt_pkg::BC_SYNC];
        if (wr_now && bus_req.address == gt_pkg::BLK_CLKSEL) begin
            next_r.clksel = bus_req.writedata[5:0] & gt_pkg::CLKSEL_MASK;
        end
        for (int i = 0; i < gt_pkg::NUM_CH; i++) begin
            // Clock source per channel; the chain taps the partner's pin A
            sel = r.clksel[i*gt_pkg::SEL_W +: gt_pkg::SEL_W];
            unique case (sel)
                gt_pkg::SRC_PIN:  ext_v[i] = clk_in[i];
                gt_pkg::SRC_NONE: ext_v[i] = 1'b0;
                gt_pkg::SRC_LO:   ext_v[i] = r.ch[(i == 0) ? 1 : 0].pa;
                gt_pkg::SRC_HI:   ext_v[i] = r.ch[(i == 2) ? 1 : 2].pa;
            endcase
            wr_ch = wr_now && bus_req.address[11:10] == 2'h0 && cix == 2'(i);
            // Read clears flags in the cycle the data is captured, so none is lost
            if (rd_now && bus_req.address[11:10] == 2'h0 && cix == 2'(i)
                && off == gt_pkg::CH_STATUS) begin
                next_r.ch[i].flags = r.ch[i].flags & ~gt_pkg::FLAG_MASK;
            end
            if (wr_ch) begin
                unique case (off)
                    gt_pkg::CH_MODE:
                        next_r.ch[i].mode = bus_req.writedata & gt_pkg::MODE_MASK;
                    gt_pkg::CH_IEN:
                        next_r.ch[i].imask = r.ch[i].imask
                            | (bus_req.writedata[7:0] & gt_pkg::FLAG_MASK);
                    gt_pkg::CH_IDIS:
                        next_r.ch[i].imask = r.ch[i].imask & ~bus_req.writedata[7:0];
                    gt_pkg::CH_CMPA: next_r.ch[i].ra = bus_req.writedata[15:0];
                    gt_pkg::CH_CMPB: next_r.ch[i].rb = bus_req.writedata[15:0];
                    gt_pkg::CH_CMPC: next_r.ch[i].rc = bus_req.writedata[15:0];
                    default: ;
                endcase
            end
            tick_v[i] = r.ch[i].clken && (r.ch[i].mode[gt_pkg::MD_EXTCLK]
                        ? (ext_v[i] && !r.ch[i].clk_prev) : 1'b1);
            next_r.ch[i].clk_prev = ext_v[i];
            next_r.ch[i].evt_prev = event_in[i];
            evt = r.ch[i].mode[gt_pkg::MD_EVSEL +: 2] != gt_pkg::EV_PIN_IN
                  && event_in[i] && !r.ch[i].evt_prev;
            nc = r.ch[i].cnt;
            if (tick_v[i]) begin
                if (r.ch[i].pend) begin
                    nc = gt_pkg::CNT_ZERO;
                    next_r.ch[i].pend = 1'b0;
                end else begin
                    nc = r.ch[i].cnt + 16'h0001;
                    if (r.ch[i].cnt == gt_pkg::CNT_MAX) begin
                        next_r.ch[i].flags[gt_pkg::ST_COV] = 1'b1;
                    end
                end
                next_r.ch[i].cnt = nc;
            end
            hit_a    = tick_v[i] && nc == r.ch[i].ra;
            hit_b[i] = tick_v[i] && nc == r.ch[i].rb;
            hit_c[i] = tick_v[i] && nc == r.ch[i].rc;
            if (hit_a) begin
                next_r.ch[i].flags[gt_pkg::ST_CPA] = 1'b1;
                next_r.ch[i].pa = pin_act(r.ch[i].pa, r.ch[i].mode[gt_pkg::MD_ACPA +: 2]);
            end
            if (hit_b[i]) begin
                next_r.ch[i].flags[gt_pkg::ST_CPB] = 1'b1;
            end
            if (hit_c[i]) begin
                next_r.ch[i].flags[gt_pkg::ST_CPC] = 1'b1;
                // Compare C wins over compare A on pin A
                next_r.ch[i].pa = pin_act(r.ch[i].pa,
                                          r.ch[i].mode[gt_pkg::MD_PIN_A_ON_COMPARE_C +: 2]);
                if (r.ch[i].mode[gt_pkg::MD_RESTART]) begin
                    next_r.ch[i].pend = 1'b1;
                end
                if (r.ch[i].mode[gt_pkg::MD_CLKOFF]) begin
                    next_r.ch[i].clken = 1'b0;
                end
                if (r.ch[i].mode[gt_pkg::MD_HALT]) begin
                    next_r.ch[i].clken = 1'b0;
                end
            end
            if (evt) begin
                next_r.ch[i].flags[gt_pkg::ST_ETRG] = 1'b1;
                next_r.ch[i].pend = 1'b1;
            end
            if (sync_now) begin
                next_r.ch[i].clken = 1'b1;
                next_r.ch[i].pend  = 1'b1;
            end
            // Only the highest event acts on pin B, and only while it is an output
            if (r.ch[i].pboe) begin
                if (sync_now) begin
                    next_r.ch[i].pb = pin_act(r.ch[i].pb, r.ch[i].mode[gt_pkg::MD_PIN_B_ON_SOFT_TRIGGER +: 2]);
                end else if (evt) begin
                    next_r.ch[i].pb = pin_act(r.ch[i].pb, r.ch[i].mode[gt_pkg::MD_PIN_B_ON_EXTERNAL_EVENT +: 2]);
                end else if (hit_c[i]) begin
                    next_r.ch[i].pb = pin_act(r.ch[i].pb,
                                              r.ch[i].mode[gt_pkg::MD_PIN_B_ON_COMPARE_C +: 2]);
                end else if (hit_b[i]) begin
                    next_r.ch[i].pb = pin_act(r.ch[i].pb,
                                              r.ch[i].mode[gt_pkg::MD_PIN_B_ON_COMPARE_B +: 2]);
                end
            end
            if (sw_rst_now) begin
                next_r.ch[i].cnt   = gt_pkg::CNT_ZERO;
                next_r.ch[i].flags = '0;
                next_r.ch[i].clken = 1'b0;
                next_r.ch[i].pend  = 1'b0;
                next_r.ch[i].pa    = 1'b0;
                next_r.ch[i].pb    = 1'b0;
            end
            next_r.ch[i].pboe = next_r.ch[i].mode[gt_pkg::MD_EVSEL +: 2] != gt_pkg::EV_PIN_IN;
            next_r.ch[i].irq  = |(next_r.ch[i].flags & next_r.ch[i].imask);
        end
        // Read data is captured in the prepare cycle and held through the answer
        if (bus_req.address == gt_pkg::BLK_CLKSEL) begin
            rd[5:0] = r.clksel;
        end else if (bus_req.address[11:10] == 2'h0 && cix != 2'h3) begin
            unique case (off)
                gt_pkg::CH_MODE:   rd = r.ch[cix].mode;
                gt_pkg::CH_STATUS: begin
                    rd[7:0]               = r.ch[cix].flags;
                    rd[gt_pkg::ST_CLKSTA] = r.ch[cix].clken;
                    rd[gt_pkg::ST_MPA]    = r.ch[cix].pa;
                    rd[gt_pkg::ST_MPB]    = r.ch[cix].pb;
                end
                gt_pkg::CH_IMASK:  rd[7:0]  = r.ch[cix].imask;
                gt_pkg::CH_CNT:    rd[15:0] = r.ch[cix].cnt;
                gt_pkg::CH_CMPA:   rd[15:0] = r.ch[cix].ra;
                gt_pkg::CH_CMPB:   rd[15:0] = r.ch[cix].rb;
                gt_pkg::CH_CMPC:   rd[15:0] = r.ch[cix].rc;
                default:           rd = '0;
            endcase
        end
        if (bus_req.read && !r.ack) begin
            next_r.rsp.readdata = rd;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.rsp.waitrequest <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus_rsp = r.rsp;
    assign waveform_pin_a    = {r.ch[2].pa, r.ch[1].pa, r.ch[0].pa};
    assign waveform_pin_b    = {r.ch[2].pb, r.ch[1].pb, r.ch[0].pb};
    assign waveform_pin_b_oe = {r.ch[2].pboe, r.ch[1].pboe, r.ch[0].pboe};
    assign chan_irq          = {r.ch[2].irq, r.ch[1].irq, r.ch[0].irq};

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    flag_b_set_a: assert property (
        hit_b[0] && !sw_rst_now
        |=> r.ch[0].flags[gt_pkg::ST_CPB] && (!r.ch[0].imask[gt_pkg::ST_CPB] || r.ch[0].irq))
        else $error("compare B match did not raise its flag");
    flag_c_set_a: assert property (
        hit_c[1] && !sw_rst_now |=> r.ch[1].flags[gt_pkg::ST_CPC])
        else $error("compare C match did not raise its flag");
    restart_c_a: assert property (
        hit_c[0] && r.ch[0].mode[gt_pkg::MD_RESTART] && !sw_rst_now
        |=> (r.ch[0].pend and (tick_v[0] |=> r.ch[0].cnt == gt_pkg::CNT_ZERO)))
        else $error("compare C restart did not zero the counter");
    clock_off_a: assert property (
        hit_c[0] && r.ch[0].mode[gt_pkg::MD_CLKOFF] && !sync_now |=> !r.ch[0].clken)
        else $error("compare C did not disable the clock");
    halt_c_a: assert property (
        hit_c[2] && r.ch[2].mode[gt_pkg::MD_HALT] && !sync_now
        |=> (!r.ch[2].clken and (!sync_now && !sw_rst_now |=> $stable(r.ch[2].cnt))))
        else $error("compare C halt did not stop the counter");
    pin_b_input_a: assert property (
        !r.ch[0].pboe && !sw_rst_now |=> $stable(r.ch[0].pb))
        else $error("pin B moved while configured as input");
    pin_a_cmp_c_a: assert property (
        hit_c[0] && r.ch[0].mode[gt_pkg::MD_PIN_A_ON_COMPARE_C +: 2] == gt_pkg::ACT_TOG && !sw_rst_now
        |=> r.ch[0].pa != $past(r.ch[0].pa))
        else $error("compare C toggle missed on pin A");
    pin_b_cmp_c_a: assert property (
        hit_c[0] && r.ch[0].pboe && !sync_now && !sw_rst_now
        && r.ch[0].mode[gt_pkg::MD_PIN_B_ON_COMPARE_C +: 2] == gt_pkg::ACT_CLR
        && !(event_in[0] && !r.ch[0].evt_prev)
        |=> !r.ch[0].pb)
        else $error("compare C clear missed on pin B");
    soft_reset_a: assert property (
        sw_rst_now |=> r.ch[0].cnt == gt_pkg::CNT_ZERO && r.ch[1].cnt == gt_pkg::CNT_ZERO
                       && r.ch[2].cnt == gt_pkg::CNT_ZERO && r.ch[2].flags == 8'h00)
        else $error("soft reset left a channel running");
    sync_all_a: assert property (
        sync_now && !sw_rst_now |=> r.ch[0].clken && r.ch[1].clken && r.ch[2].clken
                                    && r.ch[0].pend && r.ch[1].pend && r.ch[2].pend)
        else $error("sync trigger missed a channel");
    chain_src_a: assert property (
        r.clksel[3:2] == gt_pkg::SRC_LO |-> ext_v[1] == r.ch[0].pa)
        else $error("channel 1 chain clock is not channel 0 pin A");
    bus_wait_a: assert property (
        (bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
        else $error("slave did not answer after one wait cycle");
endmodule

// *** sim/gt_pins_model.sv ***
// Far-side model: external clock sources and event pins of the timer block
`timescale 1ns/1ps
module gt_pins_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] clk_en,
    input  wire logic       slow,
    output logic            clock_input_0,
    output logic            clock_input_1,
    output logic            clock_input_2,
    output logic [2:0]      event_in
);
    logic [2:0] level;
    logic       phase;

    // Sources stand low outside a burst so no stray edge reaches a counter
    // Each level lasts one clk, or two when slow
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 3'h0;
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
            level <= ((!slow || phase) ? ~level : level) & clk_en;
        end
    end

    assign clock_input_0 = level[0];
    assign clock_input_1 = level[1];
    assign clock_input_2 = level[2];
    // No external events: an event would restart the counters under test
    assign event_in      = 3'h0;
endmodule

// *** sim/timer_block_compare_chain_test.sv ***
// Self-checking bench for the three-channel timer block
`timescale 1ns/1ps
module timer_block_compare_chain_test;
    logic                clk;
    logic                rst;
    gt_pkg::gt_avl_req_t bus_req;
    gt_pkg::gt_avl_rsp_t bus_rsp;
    logic                ci0;
    logic                ci1;
    logic                ci2;
    logic [2:0]          ev;
    logic [2:0]          pa;
    logic [2:0]          pb;
    logic [2:0]          pboe;
    logic [2:0]          irq;
    logic [2:0]          clk_en;
    logic                slow;
    logic                pa0;
    logic                prev;
    logic [31:0]         rd;
    logic [31:0]         v;
    int                  mismatches;
    int                  n_compared;
    int                  seed;
    int                  rises;
    int                  hi;
    int                  lo;
    int                  n;
    int                  rb;
    int                  rc2;
    int                  t;
    int                  k;

    gt_timer_block DUT (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .clock_input_0(ci0), .clock_input_1(ci1), .clock_input_2(ci2), .event_in(ev),
        .waveform_pin_a(pa), .waveform_pin_b(pb), .waveform_pin_b_oe(pboe), .chan_irq(irq));
    gt_pins_model far (.clk(clk), .rst(rst), .clk_en(clk_en), .slow(slow),
        .clock_input_0(ci0), .clock_input_1(ci1), .clock_input_2(ci2), .event_in(ev));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then releases
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        bus_req <= '{read: !wr, write: wr, address: a, writedata: d};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (bus_rsp.waitrequest !== 1'b0 && i < 50);
        rd = bus_rsp.readdata;
        if (i >= 50) check(32'h0000_0001, 32'h0000_0000);
        bus_req <= '{default: '0};
    endtask

    task automatic wait_pb(input logic lvl, output int cnt);
        cnt = 0;
        while (pb[0] !== lvl && cnt < 40) begin
            @(posedge clk);
            cnt++;
        end
    endtask

    function automatic logic [11:0] ca(input int c, input logic [7:0] off);
        return {2'h0, 2'(c), off};
    endfunction

    // Level of the source that clock select code picks for channel ch
    function automatic logic src(input int ch, input logic [1:0] code);
        logic [2:0] cin;
        cin = {ci2, ci1, ci0};
        case (code)
            2'h0: return cin[ch];
            2'h1: return 1'b0;
            2'h2: return pa[ch == 0 ? 1 : 0];
            default: return pa[ch == 2 ? 1 : 2];
        endcase
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    initial begin
        seed = 75884;
        mismatches = 0;
        n_compared = 0;
        rst = 1'b1;
        bus_req = '{default: '0};
        clk_en = 3'h0;
        slow = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(32'({bus_rsp.waitrequest, pa, pb, pboe, irq}), 32'h0000_1000);
        for (int c = 0; c < 6; c++) begin
            v = $random(seed);
            xfer(1'b1, ca(c / 2, c % 2 ? gt_pkg::CH_CMPC : gt_pkg::CH_CMPB), v);
            xfer(1'b0, ca(c / 2, c % 2 ? gt_pkg::CH_CMPC : gt_pkg::CH_CMPB), '0);
            check(rd, v & 32'h0000_FFFF);
        end
        v = $random(seed);
        xfer(1'b1, gt_pkg::BLK_CLKSEL, v);
        xfer(1'b0, gt_pkg::BLK_CLKSEL, '0);
        check(rd, v & 32'h0000_003F);
        xfer(1'b0, gt_pkg::BLK_CTRL, '0);
        check(rd, 32'h0000_0000);
        xfer(1'b1, 12'h3F0, v);
        xfer(1'b0, 12'h3F0, '0);
        check(rd, 32'h0000_0000);

        // Compare run: ch0 pin B driven, ch1 pin B input, ch2 halts on C
        rb = 1 + ($unsigned($random(seed)) % 7);
        rc2 = 2 + ($unsigned($random(seed)) % 20);
        xfer(1'b1, gt_pkg::BLK_CTRL, 32'h0000_0001);
        xfer(1'b1, gt_pkg::BLK_CLKSEL, '0);
        for (int c = 0; c < 2; c++) begin
            xfer(1'b1, ca(c, gt_pkg::CH_CMPB), 32'(rb));
            xfer(1'b1, ca(c, gt_pkg::CH_CMPC), 32'h0000_0009);
        end
        xfer(1'b1, ca(2, gt_pkg::CH_CMPC), 32'(rc2));
        xfer(1'b1, ca(0, gt_pkg::CH_IEN), 32'h0000_0018);
        xfer(1'b1, ca(0, gt_pkg::CH_MODE), 32'h090C_4400);
        xfer(1'b1, ca(1, gt_pkg::CH_MODE), 32'h090C_4000);
        xfer(1'b1, ca(2, gt_pkg::CH_MODE), 32'h0000_0040);
        xfer(1'b1, gt_pkg::BLK_CTRL, 32'h0000_0002);
        wait_pb(1'b1, n);
        pa0 = pa[0];
        wait_pb(1'b0, hi);
        check(32'(pa[0] ^ pa0), 32'h0000_0001);
        wait_pb(1'b1, lo);
        check(32'(hi), 32'(9 - rb));
        check(32'(lo), 32'(rb + 1));
        check(32'(irq), 32'h0000_0001);
        check(32'({pboe[1:0], pb[1]}), 32'h0000_0002);
        xfer(1'b0, ca(0, gt_pkg::CH_STATUS), '0);
        check(rd & 32'h0000_0018, 32'h0000_0018);
        repeat (20) @(posedge clk);
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                xfer(1'b1, ca(2, gt_pkg::CH_MODE), 32'h0000_0080);
                xfer(1'b1, gt_pkg::BLK_CTRL, 32'h0000_0002);
                repeat (40) @(posedge clk);
            end
            xfer(1'b0, ca(2, gt_pkg::CH_CNT), '0);
            check(rd, 32'(rc2));
            xfer(1'b0, ca(2, gt_pkg::CH_STATUS), '0);
            check(rd & 32'h0000_0110, 32'h0000_0010);
        end
        xfer(1'b1, gt_pkg::BLK_CTRL, 32'h0000_0001);
        xfer(1'b0, ca(0, gt_pkg::CH_CNT), '0);
        check(rd, 32'h0000_0000);
        check(32'({pa, pb}), 32'h0000_0000);

        // Chain run: every select code of every channel, the others as sources
        for (int c = 0; c < 3; c++) xfer(1'b1, ca(c, gt_pkg::CH_CMPC), 32'h0000_0009);
        for (int i = 0; i < 12; i++) begin
            t = i / 4;
            k = i % 4;
            slow <= 1'($random(seed));
            xfer(1'b1, gt_pkg::BLK_CTRL, 32'h0000_0001);
            xfer(1'b1, gt_pkg::BLK_CLKSEL, 32'(k) << (2 * t));
            for (int c = 0; c < 3; c++) begin
                xfer(1'b1, ca(c, gt_pkg::CH_MODE), c == t ? 32'h0000_0001 : 32'h000C_4000);
            end
            xfer(1'b1, gt_pkg::BLK_CTRL, 32'h0000_0002);
            if (k == 0) clk_en <= 3'(1 << t);
            rises = 0;
            prev = 1'b0;
            for (n = 0; n < 120 && rises < 3; n++) begin
                @(posedge clk);
                if (src(t, 2'(k)) === 1'b1 && !prev) rises++;
                prev = src(t, 2'(k));
            end
            clk_en <= 3'h0;
            xfer(1'b0, ca(t, gt_pkg::CH_CNT), '0);
            check(rd, 32'(rises > 0 ? rises - 1 : 0));
        end
        finish_test();
    end
endmodule
